// ==== hdl/ral_alarm_outputs.v ====
`timescale 1ns/1ns
`include "ral_defs.vh"

// Function
// - Control bit 4 selects transmit-clock-loss function
// - Frame-loss high while synchronizer searches alignment
// - Transmit clock idle 15 scaled periods asserts
// - Composite mode: clock errors drive output high
// - 6312 kHz mode: frame-loss output undriven
// - T1: 192 consecutive zeros set signal loss
// - E1: 255 consecutive zeros set signal loss
// - Composite: zeros for 120 us set loss
module ral_alarm_outputs #(
	parameter CNT_W = 16,
	parameter CC_LOS_CYCLES = `RAL_CC_LOS_CYCLES
) (
	// Clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Receive side inputs
	input wire rx_data_valid,
	input wire rx_data,
	input wire sync_searching,
	input wire cc_8k_error,
	input wire cc_400_error,
	input wire transmit_clock_in,
	// Alarm pins
	output wire frame_loss_or_cc_error_out,
	output wire frame_loss_or_cc_error_oe,
	output wire signal_loss_out,
	// Interrupt
	output wire irq
);

	// Thresholds sized to the counter width, so no port silently truncates
	localparam [CNT_W-1:0] TRANSMIT_CLOCK_IN_LIMIT = `RAL_TRANSMIT_CLOCK_IN_LOSS_PERIODS;
	localparam [CNT_W-1:0] T1_LIMIT = `RAL_T1_ZEROS;
	localparam [CNT_W-1:0] E1_LIMIT = `RAL_E1_ZEROS;
	localparam [CNT_W-1:0] CC_LIMIT = CC_LOS_CYCLES[CNT_W-1:0];

	reg [31:0] io_control_reg;
	reg [15:0] scale_reg;
	reg [`RAL_ST_WIDTH-1:0] status_reg;
	reg [`RAL_ST_WIDTH-1:0] irq_en_reg;
	reg [31:0] prdata_reg;
	reg [15:0] scale_cnt_reg;
	reg scaled_tick_reg;
	reg transmit_clock_in_prev_reg;
	reg [`RAL_ST_WIDTH-1:0] cond_prev_reg;
	reg fl_out_reg;
	reg fl_oe_reg;
	reg los_out_reg;
	reg [CNT_W-1:0] los_limit;
	reg los_count_en;

	wire [1:0] line_mode;
	wire transmit_clock_in_sel;
	wire apb_access;
	wire apb_wr;
	wire apb_rd;
	wire addr_ok;
	wire transmit_clock_in_edge;
	wire transmit_clock_in_lost;
	wire zeros_reached;
	wire cc_error;
	wire frame_cond;
	wire [`RAL_ST_WIDTH-1:0] cond_now;
	wire [`RAL_ST_WIDTH-1:0] cond_rise;
	wire [`RAL_ST_WIDTH-1:0] clr_mask;

	// Address decode, shared by write/read enables and error answer
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `RAL_OFS_CTRL) || (a == `RAL_OFS_STATUS) ||
				(a == `RAL_OFS_IRQ_EN) || (a == `RAL_OFS_IRQ_CLR) ||
				(a == `RAL_OFS_SCALE);
		end
	endfunction

	assign line_mode = io_control_reg[`RAL_CTRL_MODE_LSB+1:`RAL_CTRL_MODE_LSB];
	assign transmit_clock_in_sel = io_control_reg[`RAL_CTRL_TRANSMIT_CLOCK_IN_SEL_BIT];

	// Zero-wait APB: every access completes in its first access cycle
	assign apb_access = psel && penable;
	assign addr_ok = is_mapped(paddr);
	assign apb_wr = apb_access && pwrite && addr_ok;
	assign apb_rd = apb_access && !pwrite && addr_ok;
	assign pready = 1'b1;
	assign pslverr = apb_access && !addr_ok;
	assign prdata = prdata_reg;

	// Software-visible configuration
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			io_control_reg <= `RAL_CTRL_RESET;
			scale_reg <= `RAL_SCALE_RESET;
			irq_en_reg <= {`RAL_ST_WIDTH{1'b0}};
		end else if (apb_wr) begin
			if (paddr == `RAL_OFS_CTRL) begin
				io_control_reg <= {27'h0000000, pwdata[4], 2'h0, pwdata[1:0]};
			end
			if (paddr == `RAL_OFS_SCALE) begin
				scale_reg <= pwdata[15:0];
			end
			if (paddr == `RAL_OFS_IRQ_EN) begin
				irq_en_reg <= pwdata[`RAL_ST_WIDTH-1:0];
			end
		end
	end

	// Read data is registered; unmapped reads return zero
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_reg <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`RAL_OFS_CTRL: prdata_reg <= io_control_reg;
				`RAL_OFS_STATUS: prdata_reg <= {28'h0000000, status_reg};
				`RAL_OFS_IRQ_EN: prdata_reg <= {28'h0000000, irq_en_reg};
				`RAL_OFS_SCALE: prdata_reg <= {16'h0000, scale_reg};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// Scaled master clock: one-cycle tick every scale_reg+1 cycles
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			scale_cnt_reg <= 16'h0000;
			scaled_tick_reg <= 1'b0;
		end else if (scale_cnt_reg >= scale_reg) begin
			scale_cnt_reg <= 16'h0000;
			scaled_tick_reg <= 1'b1;
		end else begin
			scale_cnt_reg <= scale_cnt_reg + 16'h0001;
			scaled_tick_reg <= 1'b0;
		end
	end

	// Transmit clock is sampled as a synchronous level; any change is a transition
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			transmit_clock_in_prev_reg <= 1'b0;
		end else begin
			transmit_clock_in_prev_reg <= transmit_clock_in;
		end
	end

	assign transmit_clock_in_edge = transmit_clock_in ^ transmit_clock_in_prev_reg;

	// Idle watchdog counts scaled ticks, restarted by any edge
	ral_run_counter #(
		.WIDTH(CNT_W)
	) u_transmit_clock_in_watch (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.restart(transmit_clock_in_edge),
		.count_en(scaled_tick_reg),
		.limit(TRANSMIT_CLOCK_IN_LIMIT),
		.reached(transmit_clock_in_lost)
	);

	// Loss-of-signal threshold and count source follow the line mode
	always @* begin
		los_limit = {CNT_W{1'b1}};
		los_count_en = 1'b0;
		case (line_mode)
			`RAL_MODE_T1: begin
				los_limit = T1_LIMIT;
				los_count_en = rx_data_valid;
			end
			`RAL_MODE_E1: begin
				los_limit = E1_LIMIT;
				los_count_en = rx_data_valid;
			end
			`RAL_MODE_CC: begin
				los_limit = CC_LIMIT;
				los_count_en = !rx_data;
			end
			default: begin
				los_limit = {CNT_W{1'b1}};
				los_count_en = 1'b0;
			end
		endcase
	end

	// Zero-run counter; a received one restarts it
	ral_run_counter #(
		.WIDTH(CNT_W)
	) u_zero_run (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.restart((rx_data_valid && rx_data) || (line_mode == `RAL_MODE_CC && rx_data)),
		.count_en(los_count_en && !rx_data),
		.limit(los_limit),
		.reached(zeros_reached)
	);

	assign cc_error = cc_8k_error || cc_400_error;
	assign frame_cond = sync_searching;

	// Pin drivers, registered
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fl_out_reg <= 1'b0;
			fl_oe_reg <= 1'b0;
			los_out_reg <= 1'b0;
		end else begin
			los_out_reg <= (line_mode != `RAL_MODE_6312) && zeros_reached;
			case (line_mode)
				`RAL_MODE_T1, `RAL_MODE_E1: begin
					fl_oe_reg <= 1'b1;
					if (transmit_clock_in_sel) begin
						fl_out_reg <= transmit_clock_in_lost;
					end else begin
						fl_out_reg <= frame_cond;
					end
				end
				`RAL_MODE_CC: begin
					fl_oe_reg <= 1'b1;
					fl_out_reg <= cc_error;
				end
				default: begin
					fl_oe_reg <= 1'b0;
					fl_out_reg <= 1'b0;
				end
			endcase
		end
	end

	assign frame_loss_or_cc_error_out = fl_out_reg;
	assign frame_loss_or_cc_error_oe = fl_oe_reg;
	assign signal_loss_out = los_out_reg;

	// Status events are rising edges of each alarm condition
	assign cond_now = {cc_error && line_mode == `RAL_MODE_CC, transmit_clock_in_lost,
		zeros_reached && line_mode != `RAL_MODE_6312, frame_cond};
	assign cond_rise = cond_now & ~cond_prev_reg;
	assign clr_mask = (apb_wr && paddr == `RAL_OFS_IRQ_CLR) ?
		pwdata[`RAL_ST_WIDTH-1:0] : {`RAL_ST_WIDTH{1'b0}};

	// Sticky status; a new event wins over a simultaneous clear
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cond_prev_reg <= {`RAL_ST_WIDTH{1'b0}};
			status_reg <= {`RAL_ST_WIDTH{1'b0}};
		end else begin
			cond_prev_reg <= cond_now;
			status_reg <= (status_reg & ~clr_mask) | cond_rise;
		end
	end

	assign irq = |(status_reg & irq_en_reg);

endmodule

// ==== hdl/ral_defs.vh ====
`ifndef RAL_DEFS_VH
`define RAL_DEFS_VH

// Line modes
`define RAL_MODE_T1 2'h0
`define RAL_MODE_E1 2'h1
`define RAL_MODE_CC 2'h2
`define RAL_MODE_6312 2'h3

// Register byte addresses
`define RAL_OFS_CTRL 12'h000
`define RAL_OFS_STATUS 12'h004
`define RAL_OFS_IRQ_EN 12'h008
`define RAL_OFS_IRQ_CLR 12'h00c
`define RAL_OFS_SCALE 12'h010

// Control register fields
`define RAL_CTRL_MODE_LSB 0
`define RAL_CTRL_TRANSMIT_CLOCK_IN_SEL_BIT 4
`define RAL_CTRL_RESET 32'h00000000

// Status / interrupt bit positions
`define RAL_ST_FRAME_LOSS 0
`define RAL_ST_SIGNAL_LOSS 1
`define RAL_ST_TRANSMIT_CLOCK_IN_LOSS 2
`define RAL_ST_CC_ERROR 3
`define RAL_ST_WIDTH 4

// Thresholds and timing
`define RAL_T1_ZEROS 192
`define RAL_E1_ZEROS 255
`define RAL_TRANSMIT_CLOCK_IN_LOSS_PERIODS 15
`define RAL_CC_LOS_TIME_NS 120000
`define RAL_CLK_PERIOD_NS 20
`define RAL_CC_LOS_CYCLES ((`RAL_CC_LOS_TIME_NS + `RAL_CLK_PERIOD_NS - 1) / `RAL_CLK_PERIOD_NS)
`define RAL_SCALE_RESET 16'h0007

`endif

// ==== hdl/ral_run_counter.v ====
`timescale 1ns/1ns
`include "ral_defs.vh"

// Saturating run-length counter with a threshold compare
module ral_run_counter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// Counting control
	input wire restart,
	input wire count_en,
	input wire [WIDTH-1:0] limit,
	// Result
	output wire reached
);

	reg [WIDTH-1:0] count_reg;

	// Saturate so the alarm holds through arbitrarily long runs
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= {WIDTH{1'b0}};
		end else if (restart) begin
			count_reg <= {WIDTH{1'b0}};
		end else if (count_en && count_reg != {WIDTH{1'b1}}) begin
			count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign reached = (count_reg >= limit);

endmodule

// ==== tb/ral_alarm_outputs_asserts.sv ====
`timescale 1ns/1ns
module ral_alarm_outputs_asserts (
	// Clock, reset, bus
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	// Line side
	input wire rx_data_valid,
	input wire rx_data,
	input wire sync_searching,
	input wire cc_8k_error,
	input wire cc_400_error,
	input wire transmit_clock_in,
	// Alarm pins
	input wire frame_loss_or_cc_error_out,
	input wire frame_loss_or_cc_error_oe,
	input wire signal_loss_out
);
	logic [4:0] ctl_reg;
	logic [8:0] zc_reg;
	wire [1:0] md = ctl_reg[1:0];
	wire fo = frame_loss_or_cc_error_out;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Shadow control; a mode write restarts the zero run so stale counts never match
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_reg <= 5'h00;
			zc_reg <= 9'h000;
		end else if (psel && penable && pwrite && paddr == 12'h000) begin
			ctl_reg <= pwdata[4:0];
			zc_reg <= 9'h000;
		end else if (rx_data_valid) begin
			zc_reg <= rx_data ? 9'h000 : zc_reg + 9'h001;
		end
	end
	a_frame_follow: assert property (md < 2 && !ctl_reg[4] |=> fo == $past(sync_searching))
		else $error("frame pin wrong");
	a_cc_error: assert property (md == 2 |=> fo == $past(cc_8k_error || cc_400_error))
		else $error("cc pin wrong");
	a_hiz_6312: assert property (md == 3 |=> !frame_loss_or_cc_error_oe)
		else $error("pin driven");
	a_pin_driven: assert property (md != 3 |=> frame_loss_or_cc_error_oe)
		else $error("pin undriven");
	a_transmit_clock_in_clear: assert property (md < 2 && ctl_reg[4] && $changed(transmit_clock_in) |-> ##[1:3] !fo)
		else $error("transmit_clock_in loss stuck");
	a_los_t1: assert property (md == 0 && rx_data_valid && !rx_data && zc_reg == 9'd191
		|-> ##[1:2] signal_loss_out)
		else $error("t1 los late");
	a_los_e1: assert property (md == 1 && rx_data_valid && !rx_data && zc_reg == 9'd254
		|-> ##[1:2] signal_loss_out)
		else $error("e1 los late");
	a_los_clear: assert property (md < 2 && rx_data_valid && rx_data |-> ##[1:2] !signal_loss_out)
		else $error("los stuck");
endmodule

// ==== tb/ral_alarm_monitor.sv ====
`timescale 1ns/1ns
module ral_alarm_monitor (
	// Pins
	input wire clk_sys,
	input wire frame_out,
	input wire frame_oe,
	input wire los_out,
	// Levels seen
	output wire frame_pin,
	output logic los_seen
);
	// No pull on the shared pin, so it floats when released
	assign frame_pin = frame_oe ? frame_out : 1'bz;
	// Monitor samples the loss pin each clock
	always_ff @(posedge clk_sys) begin
		los_seen <= los_out;
	end
endmodule

// ==== tb/ral_alarm_outputs_bench.sv ====
`timescale 1ns/1ns
`include "ral_defs.vh"
module ral_alarm_outputs_bench;
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic rx_data_valid = 0, rx_data = 1, sync_searching = 0, cc_8k_error = 0;
	logic cc_400_error = 0, transmit_clock_in = 0, transmit_clock_in_run = 1;
	wire [31:0] prdata;
	wire pready, pslverr, fo, foe, los, irq, pin, los_seen;
	int num_errors = 0, n_compared = 0;
	ral_alarm_outputs #(.CC_LOS_CYCLES(50)) ral_alarm_outputs_i (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_data_valid(rx_data_valid), .rx_data(rx_data), .sync_searching(sync_searching),
		.cc_8k_error(cc_8k_error), .cc_400_error(cc_400_error),
		.transmit_clock_in(transmit_clock_in), .frame_loss_or_cc_error_out(fo),
		.frame_loss_or_cc_error_oe(foe), .signal_loss_out(los), .irq(irq));
	ral_alarm_monitor ral_alarm_monitor_i (.clk_sys(clk_sys), .frame_out(fo), .frame_oe(foe),
		.los_out(los), .frame_pin(pin), .los_seen(los_seen));
	// Clock and free-running transmit clock
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (transmit_clock_in_run) transmit_clock_in <= ~transmit_clock_in;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		do cyc(1); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cyc(1);
	endtask
	task automatic bits(input logic v, input int n);
		repeat (n) begin
			rx_data <= v;
			rx_data_valid <= 1'b1;
			cyc(1);
			rx_data_valid <= 1'b0;
			cyc(1);
		end
	endtask
	task automatic t_frame;
		apb(0, `RAL_OFS_SCALE, 0);
		chk("scale reset", rd, 32'h7);
		// Tick every clock so the idle watchdog runs in 15 cycles
		apb(1, `RAL_OFS_SCALE, 0);
		apb(1, 12'h0f0, 0);
		chk("unmapped", err, 1);
		sync_searching <= 1'b1;
		cyc(3);
		chk("frame set", pin, 1);
		sync_searching <= 1'b0;
		cyc(3);
		chk("frame clr", pin, 0);
		$display("done frame");
	endtask
	task automatic t_los(input logic [1:0] m, input int n);
		apb(1, `RAL_OFS_CTRL, {30'h0, m});
		bits(1, 1);
		bits(0, n - 1);
		cyc(3);
		chk("los early", los_seen, 0);
		bits(0, 1);
		cyc(3);
		chk("los set", los_seen, 1);
		bits(1, 1);
		cyc(3);
		chk("los clr", los_seen, 0);
		$display("done los %0d", n);
	endtask
	task automatic t_transmit_clock_in;
		apb(1, `RAL_OFS_IRQ_EN, 32'h4);
		apb(1, `RAL_OFS_CTRL, 32'h10);
		sync_searching <= 1'b1;
		transmit_clock_in_run <= 1'b0;
		cyc(10);
		chk("transmit_clock_in early", pin, 0);
		cyc(10);
		chk("transmit_clock_in loss", pin, 1);
		chk("irq set", irq, 1);
		apb(1, `RAL_OFS_IRQ_EN, 0);
		chk("irq mask", irq, 0);
		transmit_clock_in_run <= 1'b1;
		sync_searching <= 1'b0;
		apb(1, `RAL_OFS_IRQ_EN, 32'h4);
		cyc(2);
		chk("transmit_clock_in back", pin, 0);
		apb(1, `RAL_OFS_IRQ_CLR, 32'h4);
		chk("irq clr", irq, 0);
		$display("done transmit_clock_in");
	endtask
	task automatic t_cc;
		apb(1, `RAL_OFS_CTRL, 32'h2);
		cc_400_error <= 1'b1;
		cyc(3);
		chk("cc 400", pin, 1);
		cc_400_error <= 1'b0;
		cyc(3);
		chk("cc clr", pin, 0);
		cc_8k_error <= 1'b1;
		rx_data <= 1'b0;
		cyc(3);
		chk("cc 8k", pin, 1);
		cyc(42);
		chk("cc los early", los_seen, 0);
		cyc(10);
		chk("cc los", los_seen, 1);
		rx_data <= 1'b1;
		cyc(4);
		chk("cc los clr", los_seen, 0);
		apb(1, `RAL_OFS_CTRL, 32'h3);
		cyc(1);
		chk("hiz", pin, 1'bz);
		$display("done cc");
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(5);
		sys_rst <= 1'b0;
		cyc(1);
		t_frame;
		t_los(`RAL_MODE_T1, `RAL_T1_ZEROS);
		t_los(`RAL_MODE_E1, `RAL_E1_ZEROS);
		t_transmit_clock_in;
		t_cc;
		wrap_up;
	end
	// Run needs about 1060 cycles
	initial begin
		#400000;
		num_errors++;
		wrap_up;
	end
endmodule
bind ral_alarm_outputs ral_alarm_outputs_asserts ral_alarm_outputs_asserts_i (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
	.sync_searching(sync_searching), .cc_8k_error(cc_8k_error), .cc_400_error(cc_400_error),
	.transmit_clock_in(transmit_clock_in), .frame_loss_or_cc_error_out(frame_loss_or_cc_error_out),
	.frame_loss_or_cc_error_oe(frame_loss_or_cc_error_oe), .signal_loss_out(signal_loss_out));
